/* File: mcu_extension_sfr_logic.sv */
module mcu_extension_sfr_logic (
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  input  wire sfr_ext_pkg::sfr_req_t sfr_req,
  output logic [7:0]                 sfr_rdata,
  output logic                       sfr_hit,
  input  wire sfr_ext_pkg::bus_cycle_t bus_cycle,
  input  wire logic                  idle_mode,
  input  wire logic                  power_down,
  input  wire logic                  core_ale,
  input  wire logic                  core_program_read_strobe,
  input  wire logic                  core_data_oe,
  output logic                       ale_out,
  output logic                       program_read_strobe,
  output logic                       ext_data_bus_oe,
  output logic [3:0]                 upper_addr_pins,
  output logic [7:0]                 high_addr_port,
  output logic [7:0]                 low_addr_port,
  output logic [7:0]                 aux_port_out,
  input  wire logic [7:0]            aux_port_in,
  input  wire logic                  irq_a_pin,
  input  wire logic                  irq_b_pin,
  input  wire logic                  irq_a_serviced,
  input  wire logic                  irq_b_serviced,
  input  wire logic [5:0]            std_irq_req,
  input  wire logic [5:0]            std_irq_high,
  output logic                       irq_valid,
  output logic                       irq_high_level,
  output logic [7:0]                 irq_vector
);
  import sfr_ext_pkg::*;

  logic [7:0] movx_page_high;        // Page byte for index-addressed data moves.
  logic [7:0] ext_addr_bank_ctrl;    // Mode bit and bank bits; reserved bits stored as ones.
  logic [7:0] aux_port_latch;        // Extra port output latch.
  logic [7:0] ext_irq_ctrl;          // Added interrupt control and status.
  logic       irq_a_prev;            // Previous level of the first added input.
  logic       irq_b_prev;            // Previous level of the second added input.
  logic [7:0] next_page;             // Next page register value.
  logic [7:0] next_bank;             // Next bank register value.
  logic [7:0] next_aux;              // Next port latch value.
  logic [7:0] next_irqc;             // Next interrupt control value.
  logic       irq_a_fall;            // Falling edge seen on the first input.
  logic       irq_b_fall;            // Falling edge seen on the second input.
  logic       chip_select_mode_bit;  // High when pins act as chip selects.
  logic       bit_hit_irqc;          // Bit write aimed at the interrupt control register.

  assign chip_select_mode_bit = ext_addr_bank_ctrl[BANK_MODE_BIT];
  assign bit_hit_irqc = sfr_req.bit_wr && (sfr_req.bit_addr[7:3] == IRQC_BIT_BASE);
  assign irq_a_fall   = irq_a_prev && !irq_a_pin;
  assign irq_b_fall   = irq_b_prev && !irq_b_pin;

  // Register next values; bit writes only reach the interrupt control register.
  always_comb begin
    next_page = movx_page_high;
    next_bank = ext_addr_bank_ctrl;
    next_aux  = aux_port_latch;
    next_irqc = ext_irq_ctrl;
    if (sfr_req.wr) begin
      unique case (sfr_req.addr)
        ADDR_PAGE: next_page = sfr_req.wdata;
        ADDR_BANK: next_bank = (sfr_req.wdata & BANK_RW_MASK) | BANK_RSVD_ONES;
        ADDR_AUX:  next_aux  = sfr_req.wdata;
        ADDR_IRQC: next_irqc = sfr_req.wdata;
        default:   next_irqc = ext_irq_ctrl;
      endcase
    end
    if (bit_hit_irqc) begin
      next_irqc[sfr_req.bit_addr[2:0]] = sfr_req.bit_val;
    end
    // Service clears the pending flag; an edge in the same cycle wins.
    if (irq_a_serviced) begin
      next_irqc[A_PEND] = 1'b0;
    end
    if (irq_b_serviced) begin
      next_irqc[B_PEND] = 1'b0;
    end
    if (ext_irq_ctrl[A_TRIG] && irq_a_fall) begin
      next_irqc[A_PEND] = 1'b1;
    end
    if (ext_irq_ctrl[B_TRIG] && irq_b_fall) begin
      next_irqc[B_PEND] = 1'b1;
    end
  end

  // Register storage, all reset synchronously to documented values.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      movx_page_high     <= RST_PAGE;
      ext_addr_bank_ctrl <= RST_BANK;
      aux_port_latch     <= RST_AUX;
      ext_irq_ctrl       <= RST_IRQC;
      irq_a_prev         <= 1'b1;
      irq_b_prev         <= 1'b1;
    end else begin
      movx_page_high     <= next_page;
      ext_addr_bank_ctrl <= next_bank;
      aux_port_latch     <= next_aux;
      ext_irq_ctrl       <= next_irqc;
      irq_a_prev         <= irq_a_pin;
      irq_b_prev         <= irq_b_pin;
    end
  end

  // Read mux; the port register returns the pin levels, not the latch.
  always_comb begin
    sfr_hit   = 1'b1;
    sfr_rdata = ZERO_BYTE;
    unique case (sfr_req.addr)
      ADDR_PAGE: sfr_rdata = movx_page_high;
      ADDR_BANK: sfr_rdata = ext_addr_bank_ctrl | BANK_RSVD_ONES;
      ADDR_AUX:  sfr_rdata = aux_port_in;
      ADDR_IRQC: sfr_rdata = ext_irq_ctrl;
      default:   sfr_hit   = 1'b0;
    endcase
  end

  assign aux_port_out = aux_port_latch;

  // Address path next values.
  logic [7:0] next_high;   // Next high address byte.
  logic [7:0] next_low;    // Next low address byte.
  logic [3:0] next_upper;  // Next upper address or chip select pins.
  logic       next_ale;    // Next address latch strobe.
  logic       next_program_read_strobe;   // Next program read strobe.
  logic       next_oe;     // Next data bus enable.
  logic       sleeping;    // Idle or power-down.

  assign sleeping = idle_mode || power_down;

  // Address ports hold in sleep; otherwise follow the running cycle.
  always_comb begin
    next_high = high_addr_port;
    next_low  = low_addr_port;
    if (!sleeping) begin
      if (bus_cycle.movx_ri) begin
        next_high = movx_page_high;
        next_low  = bus_cycle.ri;
      end else begin
        next_high = bus_cycle.addr[15:8];
        next_low  = bus_cycle.addr[7:0];
      end
    end
    // Chip selects decode the two top address bits into one low pin.
    if (chip_select_mode_bit) begin
      next_upper = ALL_CS_OFF;
      next_upper[next_high[7:6]] = 1'b0;
    end else if (!sleeping && (bus_cycle.movc || bus_cycle.movx_dptr || bus_cycle.movx_ri)) begin
      next_upper = ext_addr_bank_ctrl[3:0];
    end else begin
      next_upper = ZERO_NIB;
    end
    // Strobes: idle holds both high, power-down both low, data bus floats.
    if (power_down) begin
      next_ale  = 1'b0;
      next_program_read_strobe = 1'b0;
    end else if (idle_mode) begin
      next_ale  = 1'b1;
      next_program_read_strobe = 1'b1;
    end else begin
      next_ale  = core_ale;
      next_program_read_strobe = core_program_read_strobe;
    end
    next_oe = core_data_oe && !sleeping;
  end

  // Address and strobe output registers.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      high_addr_port      <= ZERO_BYTE;
      low_addr_port       <= ZERO_BYTE;
      upper_addr_pins     <= ZERO_NIB;
      ale_out             <= 1'b0;
      program_read_strobe <= 1'b1;
      ext_data_bus_oe     <= 1'b0;
    end else begin
      high_addr_port      <= next_high;
      low_addr_port       <= next_low;
      upper_addr_pins     <= next_upper;
      ale_out             <= next_ale;
      program_read_strobe <= next_program_read_strobe;
      ext_data_bus_oe     <= next_oe;
    end
  end

  // Interrupt requests and polling.
  logic [NUM_SRC-1:0] req_all;    // Requests in polling order.
  logic [NUM_SRC-1:0] high_all;   // Priority level per source.
  logic               irq_a_req;  // First added input requesting.
  logic               irq_b_req;  // Second added input requesting.
  logic               next_valid; // Next request valid.
  logic               next_hl;    // Next winning level.
  logic [7:0]         next_vec;   // Next vector.

  // Edge mode uses the flag, level mode the low pin; enable gates both.
  assign irq_a_req = ext_irq_ctrl[A_EN] && (ext_irq_ctrl[A_TRIG] ? ext_irq_ctrl[A_PEND] : !irq_a_pin);
  assign irq_b_req = ext_irq_ctrl[B_EN] && (ext_irq_ctrl[B_TRIG] ? ext_irq_ctrl[B_PEND] : !irq_b_pin);
  assign req_all  = {irq_b_req, irq_a_req, std_irq_req};
  assign high_all = {ext_irq_ctrl[B_PRIO], ext_irq_ctrl[A_PRIO], std_irq_high};

  // High level wins; within a level the lowest slot index wins.
  always_comb begin
    next_valid = 1'b0;
    next_hl    = 1'b0;
    next_vec   = ZERO_BYTE;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (req_all[i] && !high_all[i]) begin
        next_valid = 1'b1;
        next_vec   = VEC_BASE + 8'(i) * VEC_STEP;
      end
    end
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (req_all[i] && high_all[i]) begin
        next_valid = 1'b1;
        next_hl    = 1'b1;
        next_vec   = VEC_BASE + 8'(i) * VEC_STEP;
      end
    end
  end

  // Poll result registers.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_valid      <= 1'b0;
      irq_high_level <= 1'b0;
      irq_vector     <= ZERO_BYTE;
    end else begin
      irq_valid      <= next_valid;
      irq_high_level <= next_hl;
      irq_vector     <= next_vec;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // Exactly one select is low in chip select mode.
  a_cs_onehot: assert property ($past(chip_select_mode_bit) |-> $countones(~upper_addr_pins) == 1)
    else $error("chip select pins not one-hot low");
  // The low select tracks the top bits of the high address.
  a_cs_window: assert property ($past(chip_select_mode_bit) |-> !upper_addr_pins[high_addr_port[7:6]])
    else $error("chip select window mismatch");
  // Reserved bank bits always read as ones.
  a_bank_rsvd: assert property (sfr_req.addr == ADDR_BANK |-> sfr_rdata[6:4] == 3'b111)
    else $error("reserved bank bits not ones");
  // Reset loads the documented bank and port values.
  a_reset_vals: assert property ($past(sys_rst) |-> ext_addr_bank_ctrl == RST_BANK && aux_port_latch == RST_AUX)
    else $error("reset value wrong");
  // Fetch cycles drive zero on the upper pins in bank mode.
  a_fetch_zero: assert property (!chip_select_mode_bit && bus_cycle.fetch && !bus_cycle.movc && !bus_cycle.movx_dptr
                                 && !bus_cycle.movx_ri |=> upper_addr_pins == ZERO_NIB)
    else $error("upper pins not zero on fetch");
  // Bank bits appear on data moves in bank mode.
  a_bank_drive: assert property (!chip_select_mode_bit && !sleeping && bus_cycle.movx_dptr
                                 |=> upper_addr_pins == $past(ext_addr_bank_ctrl[3:0]))
    else $error("bank bits not driven");
  // Edge with trigger set raises the pending flag next cycle.
  a_edge_pend: assert property (ext_irq_ctrl[A_TRIG] && irq_a_fall |=> ext_irq_ctrl[A_PEND])
    else $error("edge did not set pending");
  // Service without a new edge clears the flag.
  a_serv_clear: assert property (irq_b_serviced && !(ext_irq_ctrl[B_TRIG] && irq_b_fall) |=> !ext_irq_ctrl[B_PEND])
    else $error("service did not clear pending");
  // Disabled inputs never win the poll.
  a_enable_gate: assert property (!ext_irq_ctrl[A_EN] && !ext_irq_ctrl[B_EN] |=> !(irq_valid && irq_vector >= 8'h33))
    else $error("disabled input requested");
  // Index moves drive page and index onto the address ports.
  a_page_drive: assert property (!sleeping && bus_cycle.movx_ri
                                 |=> high_addr_port == $past(movx_page_high) && low_addr_port == $past(bus_cycle.ri))
    else $error("page address not driven");
  // Idle holds both strobes high.
  a_idle_strb: assert property (idle_mode && !power_down |=> ale_out && program_read_strobe)
    else $error("idle strobes not high");
  // Power-down holds strobes low and floats the data bus.
  a_pd_strb: assert property (power_down |=> !ale_out && !program_read_strobe && !ext_data_bus_oe)
    else $error("power-down strobes not low");

  c_cs_mode:  cover property (chip_select_mode_bit && upper_addr_pins == 4'hB);
  c_edge_irq: cover property (irq_a_fall ##1 irq_valid && irq_vector == 8'h33);
  c_page_mov: cover property (bus_cycle.movx_ri ##1 high_addr_port != ZERO_BYTE);
  c_sleep:    cover property (idle_mode ##1 power_down);

endmodule : mcu_extension_sfr_logic

/* File: mcu_extension_sfr_logic_test.sv */
// Self-checking bench for the extension register logic.
module mcu_extension_sfr_logic_test;
  import sfr_ext_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic       core_clk, sys_rst, idle_mode, power_down;    // Clock, reset and sleep levels.
  sfr_req_t   req;                                         // Register access request.
  bus_cycle_t bus;                                         // Current external cycle kind.
  logic       core_ale, core_program_read_strobe, core_data_oe;
  logic       irq_a_pin, irq_b_pin, irq_a_serviced, irq_b_serviced;
  logic [5:0] std_irq_req, std_irq_high;                   // Standard sources.
  logic [7:0] sfr_rdata, high_addr_port, low_addr_port, aux_port_out, aux_port_in, irq_vector;
  logic [3:0] upper_addr_pins;                             // Bank bits or chip selects.
  logic       sfr_hit, ale_out, program_read_strobe, ext_data_bus_oe, irq_valid, irq_high_level;
  logic [7:0] shadow;                                      // Expected interrupt control value.
  int         mismatches, checks;                          // Verdict counters.

  mcu_extension_sfr_logic dut (.core_clk, .sys_rst, .sfr_req(req), .sfr_rdata, .sfr_hit,
    .bus_cycle(bus), .idle_mode, .power_down, .core_ale, .core_program_read_strobe,
    .core_data_oe, .ale_out, .program_read_strobe, .ext_data_bus_oe, .upper_addr_pins,
    .high_addr_port, .low_addr_port, .aux_port_out, .aux_port_in, .irq_a_pin, .irq_b_pin,
    .irq_a_serviced, .irq_b_serviced, .std_irq_req, .std_irq_high, .irq_valid,
    .irq_high_level, .irq_vector);

  port_loop_model far_side (.aux_port_out(aux_port_out), .aux_port_in(aux_port_in));

  // Free-running 100 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Compares one result and counts it.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Advances one cycle and lands just after the edge.
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask : tick

  // Byte write, then an idle cycle so the strobe is never re-raised in one step.
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    tick();
    req.wr = 1'b0;
    tick();
  endtask : wr8

  // Single-bit write, with the same idle cycle.
  task automatic bwr(input logic [7:0] a, input logic v);
    req.bit_addr = a;
    req.bit_val = v;
    req.bit_wr = 1'b1;
    tick();
    req.bit_wr = 1'b0;
    tick();
  endtask : bwr

  // Read data is combinational; holding the address for one cycle keeps every drive on the same offset.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    req.addr = a;
    tick();
    chk(sfr_rdata, exp);
  endtask : rd

  // Reset values and an unmapped read.
  task automatic t_reset;
    rd(ADDR_PAGE, 8'h00);
    rd(ADDR_BANK, 8'h70);
    rd(ADDR_IRQC, 8'h00);
    chk(aux_port_out, 8'hFF);
    rd(8'h55, 8'h00);
    chk(sfr_hit, 1'b0);
    rd(ADDR_AUX, 8'h00);
    chk(sfr_hit, 1'b1);
  endtask : t_reset

  // Byte access, reserved ones, port readback, refused bit access and bit-addressable control.
  task automatic t_regs;
    wr8(ADDR_PAGE, 8'h5A);
    rd(ADDR_PAGE, 8'h5A);
    wr8(ADDR_BANK, 8'h85);
    rd(ADDR_BANK, 8'hF5);
    wr8(ADDR_AUX, 8'h3C);
    chk(aux_port_out, 8'h3C);
    rd(ADDR_AUX, 8'hC3);
    bwr(8'hA1, 1'b0);
    bwr(8'hA2, 1'b0);
    rd(ADDR_PAGE, 8'h5A);
    rd(ADDR_BANK, 8'hF5);
    shadow = 8'h00;
    for (int i = 0; i < 16; i++) begin
      bwr(8'hC0 + 8'(i % 8), i < 8);
      shadow[i % 8] = (i < 8);
      rd(ADDR_IRQC, shadow);
    end
  endtask : t_regs

  // Bank mode: bank bits only on table reads and data moves; page and index on indirect moves.
  task automatic t_bank;
    wr8(ADDR_BANK, 8'h05);
    for (int k = 0; k < 4; k++) begin
      bus = '{fetch: k == 0, movc: k == 1, movx_dptr: k == 2, movx_ri: k == 3, addr: 16'hBEEF, ri: 8'h34};
      tick();
      chk(upper_addr_pins, (k == 0) ? 4'h0 : 4'h5);
      chk({high_addr_port, low_addr_port}, (k == 3) ? 16'h5A34 : 16'hBEEF);
    end
  endtask : t_bank

  // Chip-select mode: one active-low select per 16K window, at the low edge of windows 0 and 2 and the high edge of windows 1 and 3.
  task automatic t_select;
    wr8(ADDR_BANK, 8'h80);
    for (int p = 0; p < 4; p++) begin
      bus = '{fetch: p[0], movc: 1'b0, movx_dptr: !p[0], movx_ri: 1'b0,
              addr: 16'(p * 16'h4000 + (p[0] ? 16'h3FFF : 16'h0000)), ri: 8'h00};
      tick();
      chk(upper_addr_pins, 4'(~(4'h1 << p)));
    end
  endtask : t_select

  // Idle and power-down strobe levels and upper pins during sleep.
  task automatic t_sleep;
    core_data_oe = 1'b1;
    core_ale = 1'b0;
    tick();
    chk({ale_out, program_read_strobe, ext_data_bus_oe}, 3'b011);
    idle_mode = 1'b1;
    repeat (2) tick();
    chk({ale_out, program_read_strobe, ext_data_bus_oe}, 3'b110);
    chk(upper_addr_pins, 4'h7);
    power_down = 1'b1;
    repeat (2) tick();
    chk({ale_out, program_read_strobe, ext_data_bus_oe}, 3'b000);
    chk(high_addr_port, 8'hFF);
    wr8(ADDR_BANK, 8'h05);
    chk(upper_addr_pins, 4'h0);
    idle_mode = 1'b0;
    power_down = 1'b0;
    core_data_oe = 1'b0;
    core_ale = 1'b1;
  endtask : t_sleep

  // Edge and level requests, enable gating, priority and polling order.
  task automatic t_irq;
    wr8(ADDR_IRQC, 8'h05);
    irq_a_pin = 1'b0;
    repeat (3) tick();
    chk({irq_valid, irq_high_level, irq_vector}, {2'b10, 8'h33});
    rd(ADDR_IRQC, 8'h07);
    irq_a_pin = 1'b1;
    irq_a_serviced = 1'b1;
    tick();
    irq_a_serviced = 1'b0;
    repeat (2) tick();
    rd(ADDR_IRQC, 8'h05);
    chk(irq_valid, 1'b0);
    wr8(ADDR_IRQC, 8'hC0);
    irq_b_pin = 1'b0;
    repeat (3) tick();
    chk({irq_valid, irq_high_level, irq_vector}, {2'b11, 8'h3B});
    rd(ADDR_IRQC, 8'hC0);
    bwr(8'hC6, 1'b0);
    chk(irq_valid, 1'b0);
    irq_a_pin = 1'b0;
    std_irq_req = 6'h01;
    wr8(ADDR_IRQC, 8'hC4);
    chk({irq_high_level, irq_vector}, {1'b1, 8'h3B});
    bwr(8'hC7, 1'b0);
    chk({irq_high_level, irq_vector}, {1'b0, 8'h03});
    std_irq_req = 6'h00;
    repeat (2) tick();
    chk(irq_vector, 8'h33);
    // Second input in edge mode: an edge in the service cycle keeps the flag, a later service clears it.
    irq_a_pin = 1'b1;
    irq_b_pin = 1'b1;
    wr8(ADDR_IRQC, 8'h50);
    irq_b_pin = 1'b0;
    irq_b_serviced = 1'b1;
    tick();
    irq_b_serviced = 1'b0;
    rd(ADDR_IRQC, 8'h70);
    irq_b_serviced = 1'b1;
    tick();
    irq_b_serviced = 1'b0;
    rd(ADDR_IRQC, 8'h50);
  endtask : t_irq

  // Prints the verdict and ends the run.
  task automatic end_of_test;
    if (mismatches == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  // Cuts a hang short well beyond the expected run of about 130 cycles.
  initial begin
    #50000;
    mismatches++;
    end_of_test();
  end

  // Main sequence: reset for ten cycles, then each scenario in turn.
  initial begin
    mismatches = 0;
    checks = 0;
    sys_rst = 1'b1;
    req = '0;
    bus = '0;
    {idle_mode, power_down, core_data_oe, irq_a_serviced, irq_b_serviced} = '0;
    {core_ale, core_program_read_strobe, irq_a_pin, irq_b_pin} = '1;
    std_irq_req = 6'h00;
    std_irq_high = 6'h00;
    repeat (10) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    t_reset();
    t_regs();
    t_bank();
    t_select();
    t_sleep();
    t_irq();
    end_of_test();
  end
endmodule : mcu_extension_sfr_logic_test

/* File: port_loop_model.sv */
// Far side of the auxiliary port: an inverting buffer loops the latch back onto the pins.
// The complement makes a read of the pins distinguishable from a read of the latch.
module port_loop_model (
  input  wire logic [7:0] aux_port_out,
  output logic      [7:0] aux_port_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pins always show the complement of what the latch drives.
  assign aux_port_in = ~aux_port_out;
endmodule : port_loop_model

/* File: sfr_ext_pkg.sv */
package sfr_ext_pkg;

  // Direct register addresses of the added registers.
  localparam logic [7:0] ADDR_PAGE  = 8'hA1;
  localparam logic [7:0] ADDR_BANK  = 8'hA2;
  localparam logic [7:0] ADDR_AUX   = 8'hA6;
  localparam logic [7:0] ADDR_IRQC  = 8'hC0;
  // Upper five bits shared by the eight bit addresses of the interrupt control register.
  localparam logic [4:0] IRQC_BIT_BASE = 5'h18;

  // Reset values.
  localparam logic [7:0] RST_PAGE = 8'h00;
  localparam logic [7:0] RST_BANK = 8'h70;
  localparam logic [7:0] RST_AUX  = 8'hFF;
  localparam logic [7:0] RST_IRQC = 8'h00;

  // Bank register layout.
  localparam int         BANK_MODE_BIT = 7;
  localparam logic [7:0] BANK_RSVD_ONES = 8'h70;
  localparam logic [7:0] BANK_RW_MASK   = 8'h8F;

  // Interrupt control register layout, per input.
  localparam int A_TRIG = 0;
  localparam int A_PEND = 1;
  localparam int A_EN   = 2;
  localparam int A_PRIO = 3;
  localparam int B_TRIG = 4;
  localparam int B_PEND = 5;
  localparam int B_EN   = 6;
  localparam int B_PRIO = 7;

  // Polling order slots and vectors of the two added inputs.
  localparam int         NUM_SRC    = 8;
  localparam int         SLOT_A     = 6;
  localparam int         SLOT_B     = 7;
  localparam logic [7:0] VEC_BASE   = 8'h03;
  localparam logic [7:0] VEC_STEP   = 8'h08;
  localparam logic [7:0] ZERO_BYTE  = 8'h00;
  localparam logic [3:0] ZERO_NIB   = 4'h0;
  localparam logic [3:0] ALL_CS_OFF = 4'hF;

  // Register access request from the core's direct-address path.
  typedef struct packed {
    logic       wr;        // Byte write strobe.
    logic [7:0] addr;      // Direct register address.
    logic [7:0] wdata;     // Byte write data.
    logic       bit_wr;    // Single-bit write strobe.
    logic [7:0] bit_addr;  // Bit address.
    logic       bit_val;   // Value written to the bit.
  } sfr_req_t;

  // Kind of external bus cycle the core is running, with its address sources.
  typedef struct packed {
    logic        fetch;     // Instruction fetch.
    logic        movc;      // Table read from code space.
    logic        movx_dptr; // Data move addressed by the data pointer.
    logic        movx_ri;   // Data move addressed by an index register.
    logic [15:0] addr;      // Program counter or data pointer address.
    logic [7:0]  ri;        // Index register value.
  } bus_cycle_t;

endpackage : sfr_ext_pkg
